//--- src/pmf_fifo.sv
// Descriptor FIFO with registered head and registered ready
`timescale 1ns/1ns
module pmf_fifo import pmf_pkg::*; #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Channel
	pmf_fifo_if.fifo ch
);
	localparam int unsigned PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wptr;
		logic [PW-1:0]           rptr;
		logic [PW:0]             cnt;
		logic                    ready;
		logic                    head_vld;
		logic [W-1:0]            head;
	} pmf_fifo_state_t;

	pmf_fifo_state_t st_ff;
	pmf_fifo_state_t nxt_st;

	logic push;
	logic load;

	// Head register refills from memory whenever it empties or is taken
	always_comb begin
		nxt_st = st_ff;
		push   = ch.push_valid && st_ff.ready;
		load   = (st_ff.cnt != '0) && (!st_ff.head_vld || ch.pop_ready);
		if (ch.pop_ready && st_ff.head_vld) begin
			nxt_st.head_vld = 1'b0;
		end
		if (load) begin
			nxt_st.head     = st_ff.mem[st_ff.rptr];
			nxt_st.head_vld = 1'b1;
			nxt_st.rptr     = PW'(st_ff.rptr + 1'b1);
		end
		if (push) begin
			nxt_st.mem[st_ff.wptr] = ch.push_data;
			nxt_st.wptr            = PW'(st_ff.wptr + 1'b1);
		end
		nxt_st.cnt   = (PW+1)'(st_ff.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, load});
		// Registered so the upstream sees back-pressure without a combinational path
		nxt_st.ready = nxt_st.cnt < (PW+1)'(DEPTH);
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ch.push_ready = st_ff.ready;
	assign ch.pop_valid  = st_ff.head_vld;
	assign ch.pop_data   = st_ff.head;

endmodule : pmf_fifo

//--- src/pmf_fifo_if.sv
// Valid/ready channel between the descriptor FIFO and the filter
`timescale 1ns/1ns
interface pmf_fifo_if #(
	parameter int unsigned W = 8
);
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;

	modport fifo (
		input  push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data
	);
	modport user (
		output push_valid, push_data, pop_ready,
		input  push_ready, pop_valid, pop_data
	);
endinterface : pmf_fifo_if

//--- src/pmf_msg_filter.sv
// PTP message classification, forwarding and checksum filter with control registers
// Function
// RQ1: Unicast enabled: UDP port 319/320, non-reserved address is unicast PTP, lookup-forwarded.
// RQ2: Unicast disabled: only multicast (reserved-address) frames are PTP.
// RQ3: Alternate master on: same-domain Sync/Delay_Req from master go to non-host ports.
// RQ4: Alternate master off: discard same-domain ones at host; other domains to non-host.
// RQ5: All-message priority set: every PTP message uses highest-priority queue.
// RQ6: All-message priority clear: only event messages use highest-priority queue.
// RQ7: Sync pairing: Follow_Up reaches host only when matching stored Sync identity.
// RQ8: Delay pairing: Delay_Resp reaches host only when matching stored Delay_Req identity.
// RQ9: Peer pairing: Pdelay_Resp/Follow_Up reach host only when matching Pdelay_Req.
// RQ10: Auto drop: Sync, Follow_Up, Delay_Req dropped while best master unknown.
// RQ11: Domain check: matching domain goes to host, mismatching PTP message dropped.
// RQ12: Checksum on: modified IPv4 frames get recomputed checksum.
// RQ13: Checksum off: modified IPv4 frames get zero checksum.
// RQ14: An IPv4 checksum arriving as zero stays zero.
// RQ15: IPv6/UDP PTP frames always get the updated checksum.
// RQ16: Reset enables unicast and checksum calculation, clears other control fields.
// RQ17: Eight-bit writable domain value is compared with received domain numbers.
// RQ18: Reserved control bits read zero and writes to them do nothing.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module pmf_msg_filter import pmf_pkg::*; #(
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rstn,
	// Register port
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	// Switch state
	input  wire logic              i_best_master_selection_known,
	// Descriptor input stream
	input  wire logic              i_desc_valid,
	input  wire pmf_desc_t         i_desc,
	output logic                   o_desc_ready,
	// Verdict output stream
	output logic                   o_verdict_valid,
	output pmf_verdict_t           o_verdict,
	input  wire logic              i_verdict_ready
);

	typedef struct packed {
		logic [15:0]  ctrl;
		logic [7:0]   domain;
		logic [15:0]  rdata;
		logic [15:0]  drops;
		pmf_pair_t    sync_id;
		pmf_pair_t    dreq_id;
		pmf_pair_t    pdreq_id;
		logic         out_vld;
		pmf_verdict_t out;
	} pmf_state_t;

	pmf_state_t   st_ff;
	pmf_state_t   nxt_st;

	pmf_fifo_if #(.W($bits(pmf_desc_t))) fch ();

	pmf_fifo #(
		.W     ($bits(pmf_desc_t)),
		.DEPTH (DEPTH)
	) u_fifo (
		.i_clock (i_clock),
		.i_rstn  (i_rstn),
		.ch      (fch)
	);

	pmf_desc_t    d;
	pmf_verdict_t v;
	pmf_pair_t    cur_id;
	logic         take;
	logic         is_unicast;
	logic         is_mcast;
	logic         same_dom;
	logic         is_sync_dreq;
	logic         host_ok;
	logic         nonhost_ok;
	logic         drop_bmc;
	logic         drop_dom;
	logic         pair_fail;

	assign fch.push_valid = i_desc_valid;
	assign fch.push_data  = i_desc;
	assign d              = pmf_desc_t'(fch.pop_data);
	// Output stage advances when it is empty or when the consumer takes the previous verdict
	assign take           = fch.pop_valid && (!st_ff.out_vld || i_verdict_ready);
	assign fch.pop_ready  = take;

	function automatic logic id_match(input pmf_pair_t s, input pmf_pair_t c);
		id_match = s.vld && (s.domain == c.domain) && (s.seq_id == c.seq_id) && (s.spid == c.spid);
	endfunction : id_match

	always_comb begin
		nxt_st = st_ff;
		cur_id = '{vld: 1'b1, domain: d.domain, seq_id: d.seq_id, spid: d.spid};

		// Classification
		is_mcast   = d.ptp_reserved_addr;                                              // RQ2
		is_unicast = st_ff.ctrl[BIT_UNICAST] && d.is_udp && !d.ptp_reserved_addr &&
		             ((d.udp_dport == UDP_PORT_EVENT) || (d.udp_dport == UDP_PORT_GENERAL)); // RQ1
		same_dom     = (d.domain == st_ff.domain);                                     // RQ17
		is_sync_dreq = (d.msg_type == MT_SYNC) || (d.msg_type == MT_DELAY_REQ);

		// Alternate master handling of same-domain Sync/Delay_Req from the active master
		host_ok    = 1'b1;
		nonhost_ok = 1'b1;
		if (is_sync_dreq && d.from_active_master && !d.from_host) begin
			if (st_ff.ctrl[BIT_ALT_MSTR]) begin
				host_ok    = !same_dom;                                                // RQ3
				nonhost_ok = 1'b1;                                                     // RQ3
			end else begin
				host_ok    = !same_dom;                                                // RQ4
				nonhost_ok = !same_dom;                                                // RQ4
			end
		end

		drop_bmc = st_ff.ctrl[BIT_AUTO_DROP] && !i_best_master_selection_known &&
		           (is_sync_dreq || (d.msg_type == MT_FOLLOW_UP));                     // RQ10
		drop_dom = st_ff.ctrl[BIT_DOM_CHK] && !same_dom;                               // RQ11

		// Pairing of responses with the last PTP request that was not dropped
		pair_fail = 1'b0;
		case (d.msg_type)
			MT_FOLLOW_UP: begin
				pair_fail = st_ff.ctrl[BIT_SYNC_PAIR] && !id_match(st_ff.sync_id, cur_id);  // RQ7
			end
			MT_DELAY_RESP: begin
				pair_fail = st_ff.ctrl[BIT_DLY_PAIR] && !id_match(st_ff.dreq_id, cur_id);   // RQ8
			end
			MT_PDELAY_RESP, MT_PDELAY_FUP: begin
				pair_fail = st_ff.ctrl[BIT_PDLY_PAIR] && !id_match(st_ff.pdreq_id, cur_id); // RQ9
			end
			default: begin
				pair_fail = 1'b0;
			end
		endcase

		// Verdict
		v            = '0;
		v.is_ptp     = is_mcast || is_unicast;
		v.use_lookup = !v.is_ptp || is_unicast;                                        // RQ1
		if (v.is_ptp && !is_unicast) begin
			v.drop       = drop_bmc || drop_dom || (!host_ok && !nonhost_ok);          // RQ10 RQ11 RQ4
			v.to_host    = !v.drop && host_ok && !pair_fail && !d.from_host;           // RQ7 RQ8 RQ9 RQ11
			v.to_nonhost = !v.drop && nonhost_ok;                                      // RQ3 RQ4
		end else if (v.is_ptp) begin
			v.drop       = drop_bmc || drop_dom;                                       // RQ10 RQ11
		end
		if (v.is_ptp) begin
			v.high_prio = st_ff.ctrl[BIT_ALL_PRIO] ? 1'b1 : !d.msg_type[3];            // RQ5 RQ6
		end

		// Egress checksum
		if (d.is_ipv6) begin
			v.csum = d.csum_new;                                                       // RQ15
		end else if (d.is_ipv4 && (d.csum_in == 16'h0000)) begin
			v.csum = 16'h0000;                                                         // RQ14
		end else if (d.is_ipv4 && d.modified) begin
			v.csum = st_ff.ctrl[BIT_CSUM_EN] ? d.csum_new : 16'h0000;                  // RQ12 RQ13
		end else begin
			v.csum = d.csum_in;
		end

		// Output stage and pairing memory
		if (st_ff.out_vld && i_verdict_ready) begin
			nxt_st.out_vld = 1'b0;
		end
		if (take) begin
			nxt_st.out     = v;
			nxt_st.out_vld = 1'b1;
			if (v.drop) begin
				nxt_st.drops = 16'(st_ff.drops + 16'h0001);
			end
			if (v.is_ptp && !v.drop) begin
				case (d.msg_type)
					MT_SYNC: begin
						nxt_st.sync_id = cur_id;                                       // RQ7
					end
					MT_DELAY_REQ: begin
						nxt_st.dreq_id = cur_id;                                       // RQ8
					end
					MT_PDELAY_REQ: begin
						nxt_st.pdreq_id = cur_id;                                      // RQ9
					end
					default: begin
						nxt_st.pdreq_id = st_ff.pdreq_id;
					end
				endcase
			end
		end
		// Register writes
		if (i_wr) begin
			case (i_addr)
				OFS_CTRL: begin
					nxt_st.ctrl = i_wdata & CTRL_WMASK;                                // RQ18
				end
				OFS_DOMAIN: begin
					nxt_st.domain = i_wdata[7:0];                                      // RQ17
				end
				OFS_DROPS: begin
					nxt_st.drops = DROPS_RESET;
				end
				default: begin
					nxt_st.ctrl = st_ff.ctrl;
				end
			endcase
		end

		// Register reads, answered in the next cycle; unmapped reads give zero
		nxt_st.rdata = 16'h0000;
		if (i_rd) begin
			case (i_addr)
				OFS_CTRL: begin
					nxt_st.rdata = st_ff.ctrl & CTRL_WMASK;                            // RQ18
				end
				OFS_DOMAIN: begin
					nxt_st.rdata = {8'h00, st_ff.domain};
				end
				OFS_STATUS: begin
					nxt_st.rdata = {11'h000, st_ff.pdreq_id.vld, st_ff.dreq_id.vld,
					                st_ff.sync_id.vld, fch.pop_valid, fch.push_ready};
				end
				OFS_DROPS: begin
					nxt_st.rdata = st_ff.drops;
				end
				default: begin
					nxt_st.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff        <= '0;
			st_ff.ctrl   <= CTRL_RESET;                                                // RQ16
			st_ff.domain <= DOMAIN_RESET;
			st_ff.drops  <= DROPS_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rdata         = st_ff.rdata;
	// FIFO's own ready flop: a delayed copy would let pushes and the upstream accept disagree
	assign o_desc_ready    = fch.push_ready;
	assign o_verdict_valid = st_ff.out_vld;
	assign o_verdict       = st_ff.out;

endmodule : pmf_msg_filter

//--- src/pmf_pkg.sv
// Constants, register map and frame descriptor types of the PTP message filter
package pmf_pkg;

	// Register port widths
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;

	// Register offsets
	localparam logic [15:0] OFS_CTRL   = 16'h0516;
	localparam logic [15:0] OFS_DOMAIN = 16'h0518;
	localparam logic [15:0] OFS_STATUS = 16'h0600;
	localparam logic [15:0] OFS_DROPS  = 16'h0602;

	// Control register field positions
	localparam int unsigned BIT_UNICAST   = 12;
	localparam int unsigned BIT_ALT_MSTR  = 11;
	localparam int unsigned BIT_ALL_PRIO  = 10;
	localparam int unsigned BIT_SYNC_PAIR = 9;
	localparam int unsigned BIT_DLY_PAIR  = 8;
	localparam int unsigned BIT_PDLY_PAIR = 7;
	localparam int unsigned BIT_AUTO_DROP = 5;
	localparam int unsigned BIT_DOM_CHK   = 4;
	localparam int unsigned BIT_CSUM_EN   = 2;

	// Reset values and writable-bit mask
	localparam logic [15:0] CTRL_RESET   = 16'h1004;
	localparam logic [15:0] CTRL_WMASK   = 16'h1fb4;
	localparam logic [7:0]  DOMAIN_RESET = 8'h00;
	localparam logic [15:0] DROPS_RESET  = 16'h0000;

	// PTP UDP ports (319 event, 320 general)
	localparam logic [15:0] UDP_PORT_EVENT   = 16'h013f;
	localparam logic [15:0] UDP_PORT_GENERAL = 16'h0140;

	// PTP message types
	localparam logic [3:0] MT_SYNC        = 4'h0;
	localparam logic [3:0] MT_DELAY_REQ   = 4'h1;
	localparam logic [3:0] MT_PDELAY_REQ  = 4'h2;
	localparam logic [3:0] MT_PDELAY_RESP = 4'h3;
	localparam logic [3:0] MT_FOLLOW_UP   = 4'h8;
	localparam logic [3:0] MT_DELAY_RESP  = 4'h9;
	localparam logic [3:0] MT_PDELAY_FUP  = 4'ha;

	// Descriptor FIFO depth and source port identity width
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned SPID_W     = 80;

	// Parsed frame descriptor delivered by the ingress parser
	typedef struct packed {
		logic [7:0]        domain;
		logic [15:0]       seq_id;
		logic [SPID_W-1:0] spid;
		logic [3:0]        msg_type;
		logic [15:0]       udp_dport;
		logic              ptp_reserved_addr;
		logic              is_udp;
		logic              is_ipv4;
		logic              is_ipv6;
		logic              from_host;
		logic              from_active_master;
		logic              modified;
		logic [15:0]       csum_in;
		logic [15:0]       csum_new;
	} pmf_desc_t;

	// Identity kept for request/response pairing
	typedef struct packed {
		logic              vld;
		logic [7:0]        domain;
		logic [15:0]       seq_id;
		logic [SPID_W-1:0] spid;
	} pmf_pair_t;

	// Forwarding verdict of one frame
	typedef struct packed {
		logic        is_ptp;
		logic        use_lookup;
		logic        to_host;
		logic        to_nonhost;
		logic        high_prio;
		logic        drop;
		logic [15:0] csum;
	} pmf_verdict_t;

endpackage : pmf_pkg

//--- tb/pmf_msg_filter_asserts.sv
// Port-level assertions for the PTP message filter
`timescale 1ns/1ns
module pmf_msg_filter_asserts import pmf_pkg::*; (
	// Clock and reset
	input wire logic              i_clock,
	input wire logic              i_rstn,
	// Register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	// Streams
	input wire logic              i_best_master_selection_known,
	input wire logic              i_desc_valid,
	input wire pmf_desc_t         i_desc,
	input wire logic              o_desc_ready,
	input wire logic              o_verdict_valid,
	input wire pmf_verdict_t      o_verdict,
	input wire logic              i_verdict_ready
);
	// Shadow of the control register; only valid while no verdict straddles a write
	logic [15:0] ctrl_ff;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_ff <= CTRL_RESET;
		end else if (i_wr && i_addr == OFS_CTRL) begin
			ctrl_ff <= i_wdata & CTRL_WMASK;
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside its slot");
	ctrl_read_a: assert property ($past(i_rd) && $past(i_addr) == OFS_CTRL |-> o_rdata == ctrl_ff)
		else $error("control read differs from written value");
	dom_upper_a: assert property ($past(i_rd) && $past(i_addr) == OFS_DOMAIN |-> o_rdata[15:8] == 8'h00)
		else $error("domain upper byte not zero");
	verdict_hold_a: assert property (o_verdict_valid && !i_verdict_ready |=> o_verdict_valid && $stable(o_verdict))
		else $error("verdict not held");
	all_prio_a: assert property (o_verdict_valid && o_verdict.is_ptp && ctrl_ff[BIT_ALL_PRIO] |-> o_verdict.high_prio)
		else $error("PTP message not high priority");
	mcast_only_a: assert property (o_verdict_valid && o_verdict.is_ptp && !ctrl_ff[BIT_UNICAST] |-> !o_verdict.use_lookup)
		else $error("unicast PTP seen while disabled");
	drop_route_a: assert property (o_verdict_valid && o_verdict.drop |-> !o_verdict.to_host && !o_verdict.to_nonhost)
		else $error("dropped frame still forwarded");
	non_ptp_a: assert property (o_verdict_valid && !o_verdict.is_ptp |-> o_verdict.use_lookup && !o_verdict.high_prio)
		else $error("non PTP frame handled as PTP");
endmodule : pmf_msg_filter_asserts
bind pmf_msg_filter pmf_msg_filter_asserts i_chk (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.i_best_master_selection_known, .i_desc_valid, .i_desc, .o_desc_ready, .o_verdict_valid, .o_verdict,
	.i_verdict_ready);

//--- tb/pmf_msg_filter_tb.sv
// Self-checking bench for the PTP message filter
`timescale 1ns/1ns
module pmf_msg_filter_tb import pmf_pkg::*;;
	logic         i_clock = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_desc_valid = 0;
	logic         bmk = 0, stall = 0, rd_d = 0, rdy, full_seen = 0;
	logic         o_desc_ready, o_verdict_valid;
	logic [15:0]  i_addr = '0, i_wdata = '0, o_rdata, ctl, dom, ndrop, e16;
	pmf_desc_t    i_desc = '0;
	pmf_verdict_t o_verdict, ev;
	pmf_pair_t    pm[4] = '{default: '0};
	logic [15:0]  rq[$];
	pmf_verdict_t vq[$];
	logic [15:0]  cfg[5] = '{16'hffff, 16'h0000, 16'h0e90, 16'h1fb4, 16'h134c};
	logic [3:0]   mt[8] = '{MT_SYNC, MT_DELAY_REQ, MT_PDELAY_REQ, MT_PDELAY_RESP, MT_FOLLOW_UP,
		MT_DELAY_RESP, MT_PDELAY_FUP, 4'hb};
	int           err_total = 0, n_tests = 0, cyc = 0;

	pmf_msg_filter i_pmf_msg_filter (.i_clock, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_best_master_selection_known(bmk), .i_desc_valid, .i_desc, .o_desc_ready, .o_verdict_valid,
		.o_verdict, .i_verdict_ready(rdy));
	pmf_verdict_sink i_pmf_verdict_sink (.i_clock, .i_stall(stall), .o_ready(rdy));

	always #5 i_clock = ~i_clock;

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	function automatic pmf_verdict_t ref_v(input pmf_desc_t d);
		pmf_verdict_t v;
		logic         res, sd, sm, ok;
		int           k, j;
		v = '0;
		res = d.ptp_reserved_addr;
		sd = d.domain == dom[7:0];
		v.is_ptp = res || (ctl[BIT_UNICAST] && d.is_udp && d.udp_dport inside {UDP_PORT_EVENT, UDP_PORT_GENERAL});
		v.use_lookup = !(v.is_ptp && res);
		sm = d.msg_type inside {MT_SYNC, MT_DELAY_REQ} && d.from_active_master && !d.from_host && sd;
		v.drop = v.is_ptp && ((ctl[BIT_AUTO_DROP] && !bmk && d.msg_type inside {MT_SYNC, MT_FOLLOW_UP, MT_DELAY_REQ})
			|| (ctl[BIT_DOM_CHK] && !sd) || (res && sm && !ctl[BIT_ALT_MSTR]));
		k = d.msg_type == MT_FOLLOW_UP ? 0 : d.msg_type == MT_DELAY_RESP ? 1 :
			d.msg_type inside {MT_PDELAY_RESP, MT_PDELAY_FUP} ? 2 : 3;
		ok = k == 3 || !ctl[BIT_SYNC_PAIR - k] || pm[k] == {1'b1, d.domain, d.seq_id, d.spid};
		v.to_host = res && !v.drop && !d.from_host && !sm && ok;
		v.to_nonhost = res && !v.drop;
		v.high_prio = v.is_ptp && (ctl[BIT_ALL_PRIO] || d.msg_type < 4'h8);
		if (d.is_ipv6) v.csum = d.csum_new;
		else if (d.is_ipv4 && d.csum_in == 16'h0000) v.csum = '0;
		else if (d.is_ipv4 && d.modified) v.csum = ctl[BIT_CSUM_EN] ? d.csum_new : '0;
		else v.csum = d.csum_in;
		j = d.msg_type == MT_SYNC ? 0 : d.msg_type == MT_DELAY_REQ ? 1 : d.msg_type == MT_PDELAY_REQ ? 2 : 3;
		if (v.is_ptp && !v.drop && j < 3) pm[j] = {1'b1, d.domain, d.seq_id, d.spid};
		ndrop += 16'(v.drop);
		return v;
	endfunction : ref_v

	// Narrow id ranges so that requests and responses pair up often
	function automatic pmf_desc_t rnd_d();
		pmf_desc_t d;
		d = '0;
		d.domain = dom[7:0] + 8'($urandom_range(1));
		d.seq_id = 16'($urandom_range(1));
		d.spid = 80'($urandom_range(1));
		d.msg_type = mt[$urandom_range(7)];
		d.udp_dport = $urandom_range(2) == 0 ? 16'h0050 : UDP_PORT_EVENT + 16'($urandom_range(1));
		{d.ptp_reserved_addr, d.is_udp, d.from_host, d.from_active_master, d.modified} = 5'($urandom);
		d.is_ipv4 = 1'($urandom_range(1));
		d.is_ipv6 = !d.is_ipv4 && $urandom_range(1);
		d.csum_in = 16'($urandom_range(2));
		d.csum_new = 16'($urandom);
		return d;
	endfunction : rnd_d

	// Strobes stay as set until the next access or rel, so accesses run back to back
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] v);
		i_wr <= w;
		i_rd <= !w;
		i_addr <= a;
		i_wdata <= v;
		if (!w) rq.push_back(v);
		@(posedge i_clock);
	endtask : acc

	task automatic rel();
		i_wr <= 1'b0;
		i_rd <= 1'b0;
	endtask : rel

	task automatic send(input pmf_desc_t d);
		i_desc_valid <= 1'b1;
		i_desc <= d;
		do @(posedge i_clock); while (!o_desc_ready);
		vq.push_back(ref_v(d));
	endtask : send

	always @(posedge i_clock) begin
		cyc++;
		rd_d <= i_rd;
		if (i_desc_valid && !o_desc_ready && i_rstn) full_seen <= 1'b1;
		if (rd_d) begin
			e16 = rq.pop_front();
			n_tests++;
			if (o_rdata !== e16) begin
				err_total++;
				$display("unexpected at %0t: read %h, wanted %h", $time, o_rdata, e16);
			end
		end
		if (o_verdict_valid && rdy) begin
			ev = vq.pop_front();
			n_tests++;
			if (o_verdict !== ev) begin
				err_total++;
				$display("unexpected at %0t: verdict %h, wanted %h", $time, o_verdict, ev);
			end
		end
		if (cyc == 20000) begin
			err_total++;
			$display("unexpected at %0t: run too long", $time);
			finish_test();
		end
	end

	initial begin
		void'($urandom(18869));
		repeat (20) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(posedge i_clock);
		ctl = CTRL_RESET;
		dom = '0;
		acc(0, OFS_CTRL, CTRL_RESET);
		acc(0, OFS_DOMAIN, 16'h0000);
		acc(1, 16'h0520, 16'hffff);
		acc(0, 16'h0520, 16'h0000);
		rel();
		@(posedge i_clock);
		foreach (cfg[i]) begin
			ctl = cfg[i] & CTRL_WMASK;
			dom = {8'h00, 8'(i * 37 + 5)};
			ndrop = '0;
			bmk <= i[0];
			stall <= i == 2;
			full_seen <= 1'b0;
			acc(1, OFS_CTRL, cfg[i]);
			acc(1, OFS_DOMAIN, {8'hc3, dom[7:0]});
			acc(1, OFS_DROPS, 16'hffff);
			acc(0, OFS_CTRL, ctl);
			acc(0, OFS_DOMAIN, dom);
			rel();
			repeat (40) send(rnd_d());
			i_desc_valid <= 1'b0;
			stall <= 1'b0;
			for (int t = 0; t < 300 && (vq.size() != 0 || o_verdict_valid); t++) @(posedge i_clock);
			acc(0, OFS_DROPS, ndrop);
			acc(0, OFS_STATUS, {11'h000, pm[2].vld, pm[1].vld, pm[0].vld, 2'b01});
			rel();
			@(posedge i_clock);
			n_tests++;
			if (i == 2 && !full_seen) begin
				err_total++;
				$display("unexpected at %0t: FIFO never refused", $time);
			end
			n_tests++;
			if (vq.size() != 0) begin
				err_total++;
				$display("unexpected at %0t: %0d verdicts missing", $time, vq.size());
			end
			$display("test %0d done", i);
		end
		finish_test();
	end
endmodule : pmf_msg_filter_tb

//--- tb/pmf_verdict_sink.sv
// Verdict consumer: random back-pressure, or a long total stall on request
`timescale 1ns/1ns
module pmf_verdict_sink (
	input  wire logic i_clock,
	input  wire logic i_stall,
	output logic      o_ready
);
	int quiet = 0;
	initial o_ready = 1'b0;
	// Stall long enough to fill the FIFO, then resume so the run cannot hang
	always @(posedge i_clock) begin
		quiet <= i_stall ? quiet + 1 : 0;
		o_ready <= (!i_stall || quiet > 60) && ($urandom_range(3) != 0);
	end
endmodule : pmf_verdict_sink
